// ---- omc_config_bank.v ----
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.vh"

module omc_config_bank (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // sequencer side
    input  wire        slot_run,
    input  wire [2:0]  active_slot,
    input  wire        led_turn_on,
    input  wire        dark_sample_done,
    input  wire        exposure_active,
    // applied settings
    output reg         led_driver_a_en,
    output reg  [7:0]  driver_a_current_code,
    output reg  [9:0]  led_driver_a_current,
    output reg         led_driver_b_en,
    output reg  [7:0]  driver_b_current_code,
    output reg  [9:0]  led_driver_b_current,
    output reg  [1:0]  led_current_range,
    output reg  [7:0]  led_full_scale_ma,
    output reg  [1:0]  driver_a_pin_sel,
    output reg  [1:0]  driver_b_pin_sel,
    output reg         no_led_sample_flag,
    output reg  [1:0]  photodiode_route,
    output reg  [1:0]  integration_time_sel,
    output reg  [2:0]  burst_average_sel,
    output reg         cubic_decimation_en,
    output reg         ambient_reject_method,
    output reg  [1:0]  adc_full_scale_sel_1,
    output reg  [1:0]  adc_full_scale_sel_2,
    output reg  [4:0]  offset_current_1_ua,
    output reg  [4:0]  offset_current_2_ua,
    output reg         integration_start,
    output reg         exposure_sample_start
);

////////////////////////////////////////////////////////////////////////////
// helpers

function is_mapped;
    input [11:0] addr;
    reg   [7:0]  idx;
    begin
        idx = addr[9:2];
        is_mapped = (addr[11:10] == 2'h0) &&
                    (idx >= `OMC_IDX_FIRST_SLOT) &&
                    (idx <= `OMC_IDX_LAST_SLOT) &&
                    (idx[2:0] != 3'h7);
    end
endfunction

// flat storage index: slot times eight plus position
function [5:0] store_index;
    input [11:0] addr;
    reg   [7:0]  rel;
    begin
        rel = addr[9:2] - `OMC_IDX_FIRST_SLOT;
        store_index = rel[5:0];
    end
endfunction

function [7:0] bit_mask;
    input [2:0] k;
    begin
        case (k)
            `OMC_K_SELECT: bit_mask = `OMC_MASK_SELECT;
            `OMC_K_CFG1:   bit_mask = `OMC_MASK_CFG1;
            `OMC_K_CFG2:   bit_mask = `OMC_MASK_CFG2;
            `OMC_K_CFG3:   bit_mask = `OMC_MASK_CFG3;
            `OMC_K_CFG4:   bit_mask = `OMC_MASK_CFG4;
            `OMC_K_DRV_A:  bit_mask = `OMC_MASK_DRV;
            `OMC_K_DRV_B:  bit_mask = `OMC_MASK_DRV;
            default:       bit_mask = 8'h00;
        endcase
    end
endfunction

function [7:0] reset_value;
    input [2:0] k;
    begin
        case (k)
            `OMC_K_SELECT: reset_value = `OMC_RST_SELECT;
            `OMC_K_CFG1:   reset_value = `OMC_RST_CFG1;
            `OMC_K_CFG2:   reset_value = `OMC_RST_CFG2;
            `OMC_K_CFG3:   reset_value = `OMC_RST_CFG3;
            `OMC_K_CFG4:   reset_value = `OMC_RST_CFG4;
            default:       reset_value = `OMC_RST_DRV;
        endcase
    end
endfunction

// code times step; step in 0.125 mA units is range plus one
function [9:0] drive_current;
    input [7:0] code;
    input [1:0] range;
    begin
        drive_current = {2'h0, code} * ({8'h00, range} + 10'h001);
    end
endfunction

function [11:0] led_settle_cycles;
    input [1:0] code;
    begin
        case (code)
            2'h0:    led_settle_cycles = `OMC_LED_SETTLE0_CYC;
            2'h1:    led_settle_cycles = `OMC_LED_SETTLE1_CYC;
            2'h2:    led_settle_cycles = `OMC_LED_SETTLE2_CYC;
            default: led_settle_cycles = `OMC_LED_SETTLE3_CYC;
        endcase
    end
endfunction

function [11:0] pd_settle_cycles;
    input [2:0] code;
    begin
        case (code)
            3'h0:    pd_settle_cycles = `OMC_PD_SETTLE0_CYC;
            3'h1:    pd_settle_cycles = `OMC_PD_SETTLE1_CYC;
            3'h2:    pd_settle_cycles = `OMC_PD_SETTLE2_CYC;
            3'h3:    pd_settle_cycles = `OMC_PD_SETTLE3_CYC;
            3'h4:    pd_settle_cycles = `OMC_PD_SETTLE4_CYC;
            3'h5:    pd_settle_cycles = `OMC_PD_SETTLE5_CYC;
            3'h6:    pd_settle_cycles = `OMC_PD_SETTLE6_CYC;
            default: pd_settle_cycles = `OMC_PD_SETTLE7_CYC;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// register storage, six slots of eight indices

reg  [7:0]  cfg_mem [0:47];
reg  [11:0] wr_addr;
reg         wr_addr_held;
reg  [7:0]  wr_data;
reg         wr_strb0;
reg         wr_data_held;
integer     i;

assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
assign s_axi_wready  = !wr_data_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire        do_write = wr_addr_held && wr_data_held;
wire [5:0]  wr_idx   = store_index(wr_addr);

// address and data may arrive in either order; the response waits for both
always @(posedge aclk) begin
    if (!aresetn) begin
        wr_addr_held <= 1'b0;
        wr_data_held <= 1'b0;
        wr_addr      <= 12'h000;
        wr_data      <= 8'h00;
        wr_strb0     <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `OMC_RESP_OKAY;
        for (i = 0; i < 48; i = i + 1) begin
            cfg_mem[i] <= reset_value(i[2:0]);
        end
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            wr_addr      <= s_axi_awaddr;
            wr_addr_held <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata[7:0];
            wr_strb0     <= s_axi_wstrb[0];
            wr_data_held <= 1'b1;
        end
        if (do_write) begin
            wr_addr_held <= 1'b0;
            wr_data_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (is_mapped(wr_addr)) begin
                s_axi_bresp <= `OMC_RESP_OKAY;
                // only the low byte lane holds data
                if (wr_strb0) begin
                    cfg_mem[wr_idx] <= wr_data & bit_mask(wr_idx[2:0]);
                end
            end else begin
                s_axi_bresp <= `OMC_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read channel

wire [5:0] rd_idx = store_index(s_axi_araddr);

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `OMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (is_mapped(s_axi_araddr)) begin
            s_axi_rdata <= {24'h000000, cfg_mem[rd_idx]};
            s_axi_rresp <= `OMC_RESP_OKAY;
        end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `OMC_RESP_SLVERR;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// active slot view

// a slot number past the last one is treated as idle
wire       slot_live = slot_run && (active_slot < `OMC_NUM_SLOTS);
wire [5:0] base      = {active_slot, 3'h0};
wire [7:0] r_sel     = cfg_mem[base + {3'h0, `OMC_K_SELECT}];
wire [7:0] r_cfg1    = cfg_mem[base + {3'h0, `OMC_K_CFG1}];
wire [7:0] r_cfg2    = cfg_mem[base + {3'h0, `OMC_K_CFG2}];
wire [7:0] r_cfg3    = cfg_mem[base + {3'h0, `OMC_K_CFG3}];
wire [7:0] r_cfg4    = cfg_mem[base + {3'h0, `OMC_K_CFG4}];
wire [7:0] r_drv_a   = cfg_mem[base + {3'h0, `OMC_K_DRV_A}];
wire [7:0] r_drv_b   = cfg_mem[base + {3'h0, `OMC_K_DRV_B}];
wire [1:0] range     = r_cfg2[`OMC_F_LED_RANGE_HI:`OMC_F_LED_RANGE_LO];
wire       fwd_diff  = r_cfg2[`OMC_F_AMB_METHOD];
wire [2:0] ofs1      = r_cfg4[`OMC_F_OFS1_HI:`OMC_F_OFS1_LO];
wire [2:0] ofs2      = r_cfg4[`OMC_F_OFS2_HI:`OMC_F_OFS2_LO];

// outputs go to zero between slots so no stale setting drives an led
always @(posedge aclk) begin
    if (!aresetn || !slot_live) begin
        led_driver_a_en       <= 1'b0;
        driver_a_current_code <= 8'h00;
        led_driver_a_current  <= 10'h000;
        led_driver_b_en       <= 1'b0;
        driver_b_current_code <= 8'h00;
        led_driver_b_current  <= 10'h000;
        led_current_range     <= 2'h0;
        led_full_scale_ma     <= 8'h00;
        driver_a_pin_sel      <= 2'h0;
        driver_b_pin_sel      <= 2'h0;
        no_led_sample_flag    <= 1'b0;
        photodiode_route      <= 2'h0;
        integration_time_sel  <= 2'h0;
        burst_average_sel     <= 3'h0;
        cubic_decimation_en   <= 1'b0;
        ambient_reject_method <= 1'b0;
        adc_full_scale_sel_1  <= 2'h0;
        adc_full_scale_sel_2  <= 2'h0;
        offset_current_1_ua   <= 5'h00;
        offset_current_2_ua   <= 5'h00;
    end else begin
        led_driver_a_en       <= (r_drv_a != 8'h00);
        driver_a_current_code <= r_drv_a;
        led_driver_a_current  <= drive_current(r_drv_a, range);
        led_driver_b_en       <= (r_drv_b != 8'h00);
        driver_b_current_code <= r_drv_b;
        led_driver_b_current  <= drive_current(r_drv_b, range);
        led_current_range     <= range;
        // full scale is 32 mA per range step
        led_full_scale_ma     <= {1'b0, range + 2'h1, 5'h00}
                                 + {(range == 2'h3), 7'h00};
        driver_a_pin_sel      <= r_sel[`OMC_F_DRV_A_PIN_HI:`OMC_F_DRV_A_PIN_LO];
        driver_b_pin_sel      <= r_sel[`OMC_F_DRV_B_PIN_HI:`OMC_F_DRV_B_PIN_LO];
        no_led_sample_flag    <= r_sel[`OMC_F_NO_LED_SAMPLE];
        photodiode_route      <= r_cfg1[`OMC_F_PD_ROUTE_HI:`OMC_F_PD_ROUTE_LO];
        integration_time_sel  <= r_cfg1[`OMC_F_TINT_HI:`OMC_F_TINT_LO];
        burst_average_sel     <= fwd_diff ? 3'h0
                                 : r_cfg1[`OMC_F_AVER_HI:`OMC_F_AVER_LO];
        cubic_decimation_en   <= r_cfg2[`OMC_F_CUBIC_EN];
        ambient_reject_method <= fwd_diff;
        adc_full_scale_sel_1  <= r_cfg2[`OMC_F_ADC1_HI:`OMC_F_ADC1_LO];
        adc_full_scale_sel_2  <= r_cfg2[`OMC_F_ADC2_HI:`OMC_F_ADC2_LO];
        // offset dac injects only while exposing
        offset_current_1_ua   <= exposure_active
                                 ? {2'h0, ofs1} * `OMC_OFS_STEP_UA : 5'h00;
        offset_current_2_ua   <= exposure_active
                                 ? {2'h0, ofs2} * `OMC_OFS_STEP_UA : 5'h00;
    end
end

////////////////////////////////////////////////////////////////////////////
// settle timers

reg [11:0] led_cnt;
reg [11:0] pd_cnt;

// a new start restarts the count; leaving the slot abandons it
always @(posedge aclk) begin
    if (!aresetn || !slot_live) begin
        led_cnt           <= 12'h000;
        integration_start <= 1'b0;
    end else begin
        integration_start <= (led_cnt == 12'h001) && !led_turn_on;
        if (led_turn_on) begin
            led_cnt <= led_settle_cycles(
                r_cfg3[`OMC_F_LED_SETTLE_HI:`OMC_F_LED_SETTLE_LO]);
        end else if (led_cnt != 12'h000) begin
            led_cnt <= led_cnt - 12'h001;
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn || !slot_live) begin
        pd_cnt                <= 12'h000;
        exposure_sample_start <= 1'b0;
    end else begin
        exposure_sample_start <= (pd_cnt == 12'h001) && !dark_sample_done;
        if (dark_sample_done) begin
            pd_cnt <= pd_settle_cycles(
                r_cfg3[`OMC_F_PD_SETTLE_HI:`OMC_F_PD_SETTLE_LO]);
        end else if (pd_cnt != 12'h000) begin
            pd_cnt <= pd_cnt - 12'h001;
        end
    end
end

endmodule // omc_config_bank

`default_nettype wire

// ---- omc_config_bank_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.vh"
module omc_config_bank_bench;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wr;
        logic [7:0] rd;
        logic [7:0] rst;
    } omc_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, slot_run = 1'b0;
    logic [2:0]  active_slot = 3'h0;
    logic        led_turn_on = 1'b0, dark_sample_done = 1'b0;
    logic        exposure_active = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, led_driver_a_en, led_driver_b_en;
    wire [1:0]   s_axi_bresp, s_axi_rresp, led_current_range;
    wire [31:0]  s_axi_rdata;
    wire [7:0]   driver_a_current_code, driver_b_current_code;
    wire [9:0]   led_driver_a_current, led_driver_b_current;
    wire [7:0]   led_full_scale_ma;
    wire [1:0]   driver_a_pin_sel, driver_b_pin_sel, photodiode_route;
    wire [1:0]   integration_time_sel, adc_full_scale_sel_1;
    wire [1:0]   adc_full_scale_sel_2;
    wire [2:0]   burst_average_sel;
    wire         no_led_sample_flag, cubic_decimation_en;
    wire         ambient_reject_method, integration_start;
    wire         exposure_sample_start;
    wire [4:0]   offset_current_1_ua, offset_current_2_ua;
    int          n_fail = 0;
    int          check_count = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    omc_row_t    rows [6] = '{{8'h24, 8'hFF, 8'h77, 8'h00},
        {8'h25, 8'h80, 8'h80, 8'h00}, {8'h26, 8'hFF, 8'hFF, 8'h00},
        {8'h28, 8'hFF, 8'h4F, 8'h00}, {8'h29, 8'hFF, 8'hDF, 8'h18},
        {8'h2A, 8'hFF, 8'hFF, 8'h3A}};

    omc_config_bank omc_config_bank_i (.*);

    always #20 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] dat,
                          input logic stb, output logic [1:0] resp);
        logic aw_p, w_p, aw_t, w_t, got;
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h000000, dat};
        s_axi_wstrb <= {3'b000, stb};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        while (aw_p || w_p) begin
            @(negedge aclk);
            aw_t = aw_p && s_axi_awready;
            w_t = w_p && s_axi_wready;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            aw_p = aw_p && !aw_t;
            w_p = w_p && !w_t;
        end
        do begin
            @(negedge aclk);
            got = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
        end while (!got);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] dat,
                          output logic [1:0] resp);
        logic got;
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            got = s_axi_arready;
            @(posedge aclk);
        end while (!got);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            got = s_axi_rvalid;
            dat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
        end while (!got);
        s_axi_rready <= 1'b0;
    endtask

    // outputs are registered: let the new slot settle before looking
    task automatic set_slot(input logic run, input logic [2:0] slot,
                            input logic expo);
        @(posedge aclk);
        slot_run <= run;
        active_slot <= slot;
        exposure_active <= expo;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic settle(input logic pd, input int exp_n);
        int n;
        @(posedge aclk);
        led_turn_on <= !pd;
        dark_sample_done <= pd;
        @(posedge aclk);
        led_turn_on <= 1'b0;
        dark_sample_done <= 1'b0;
        n = 0;
        while (n < 3000) begin
            @(negedge aclk);
            if ((pd ? exposure_sample_start : integration_start) === 1'b1)
                break;
            @(posedge aclk);
            n++;
        end
        check(pd ? "pd settle" : "led settle", n, exp_n);
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_rd(rows[i].idx, rd, rs);
            check("reset value", rd, {24'h0, rows[i].rst});
            axi_wr(rows[i].idx, rows[i].wr, 1'b1, rs);
            check("write resp", {30'h0, rs}, {30'h0, `OMC_RESP_OKAY});
            axi_rd(rows[i].idx, rd, rs);
            check("readback", rd, {24'h0, rows[i].rd});
        end
        $display("test table done");
        axi_rd(8'h27, rd, rs);
        check("unmapped rdata", rd, 32'h0);
        check("unmapped rresp", {30'h0, rs}, {30'h0, `OMC_RESP_SLVERR});
        axi_wr(8'h27, 8'h55, 1'b1, rs);
        check("unmapped bresp", {30'h0, rs}, {30'h0, `OMC_RESP_SLVERR});
        axi_wr(8'h25, 8'h11, 1'b0, rs);
        axi_rd(8'h25, rd, rs);
        check("strobe off", rd, 32'h80);
        $display("test refusals done");
        axi_wr(8'h2D, 8'hFF, 1'b1, rs);
        axi_wr(8'h2E, 8'h00, 1'b1, rs);
        axi_wr(8'h29, 8'hCD, 1'b1, rs);
        for (int r = 0; r < 4; r++) begin
            axi_wr(8'h2A, {r[1:0], r[1:0], r[1:0], r[1:0]}, 1'b1, rs);
            set_slot(1'b1, 3'h1, 1'b0);
            check("range", {30'h0, led_current_range}, r);
            check("a current", {22'h0, led_driver_a_current}, 255 * (r + 1));
            check("full scale", {24'h0, led_full_scale_ma}, 32 * (r + 1));
            check("a enable", {31'h0, led_driver_a_en}, 1);
            check("b enable", {23'h0, led_driver_b_en, driver_b_current_code}, 0);
            check("burst", {29'h0, burst_average_sel}, r[0] ? 0 : 5);
            check("cfg1", {28'h0, photodiode_route, integration_time_sel}, 32'hD);
            check("selects", {27'h0, no_led_sample_flag, driver_b_pin_sel,
                driver_a_pin_sel}, 32'h1F);
            check("cfg2", {26'h0, cubic_decimation_en, ambient_reject_method,
                adc_full_scale_sel_2, adc_full_scale_sel_1}, {3{r[1:0]}});
        end
        axi_wr(8'h2D, 8'h00, 1'b1, rs);
        axi_wr(8'h2E, 8'hFF, 1'b1, rs);
        axi_wr(8'h2C, 8'h73, 1'b1, rs);
        set_slot(1'b1, 3'h1, 1'b1);
        check("a off", {31'h0, led_driver_a_en}, 0);
        check("b current", {22'h0, led_driver_b_current}, 1020);
        check("offset 2", {27'h0, offset_current_2_ua}, 28);
        check("offset 1", {27'h0, offset_current_1_ua}, 12);
        set_slot(1'b1, 3'h1, 1'b0);
        check("offset dark", {27'h0, offset_current_2_ua}, 0);
        set_slot(1'b1, 3'h0, 1'b0);
        check("slot 1 code", {24'h0, driver_a_current_code}, 32'h80);
        set_slot(1'b1, 3'h6, 1'b0);
        check("bad slot", {31'h0, led_driver_b_en}, 0);
        $display("test apply done");
        axi_wr(8'h23, 8'h78, 1'b1, rs); // led code 3 stays below pd code 3
        set_slot(1'b1, 3'h0, 1'b0);
        settle(1'b0, 600);
        settle(1'b1, 603);
        $display("test settle done");
        set_slot(1'b0, 3'h0, 1'b0);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h26, rd, rs);
        check("reset b code", rd, 32'h0);
        axi_rd(8'h2A, rd, rs);
        check("reset range", rd, 32'h3A);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // omc_config_bank_bench
`default_nettype wire

// ---- omc_config_bank_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module omc_config_bank_chk (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // sequencer side
    input wire logic       slot_run,
    input wire logic [2:0] active_slot,
    input wire logic       led_turn_on,
    input wire logic       dark_sample_done,
    input wire logic       exposure_active,
    // applied settings
    input wire logic       led_driver_a_en,
    input wire logic [7:0] driver_a_current_code,
    input wire logic [9:0] led_driver_a_current,
    input wire logic       led_driver_b_en,
    input wire logic [7:0] driver_b_current_code,
    input wire logic [9:0] led_driver_b_current,
    input wire logic [1:0] led_current_range,
    input wire logic [7:0] led_full_scale_ma,
    input wire logic [2:0] burst_average_sel,
    input wire logic       ambient_reject_method,
    input wire logic [4:0] offset_current_1_ua,
    input wire logic [4:0] offset_current_2_ua,
    input wire logic       integration_start,
    input wire logic       exposure_sample_start
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire        live = slot_run && (active_slot < 3'h6);
    wire [9:0]  step = {8'h00, led_current_range} + 10'h001;
    logic [11:0] led_age;
    logic [11:0] pd_age;
    // ages saturate, so a pulse with no cause never lands in range
    always_ff @(posedge aclk) begin
        if (!aresetn || !live) begin
            led_age <= 12'hFFF;
            pd_age <= 12'hFFF;
        end else begin
            led_age <= led_turn_on ? 12'h000
                     : led_age + {11'h000, led_age != 12'hFFF};
            pd_age <= dark_sample_done ? 12'h000
                    : pd_age + {11'h000, pd_age != 12'hFFF};
        end
    end
    sequence s_dark;
        !led_driver_a_en && !led_driver_b_en && led_full_scale_ma == 8'h00;
    endsequence
    sequence s_no_offset;
        offset_current_1_ua == 5'h00 && offset_current_2_ua == 5'h00;
    endsequence
    drv_a_off_a: assert property (led_driver_a_en == (driver_a_current_code != 8'h00))
        else $error("driver a enable disagrees with its code");
    drv_b_off_a: assert property (led_driver_b_en == (driver_b_current_code != 8'h00))
        else $error("driver b enable disagrees with its code");
    drv_a_scale_a: assert property (led_driver_a_current == {2'b00, driver_a_current_code} * step)
        else $error("driver a current not code times step");
    drv_b_scale_a: assert property (led_driver_b_current == {2'b00, driver_b_current_code} * step)
        else $error("driver b current not code times step");
    full_scale_a: assert property ($past(live) |-> led_full_scale_ma == step[7:0] * 8'h20)
        else $error("full scale does not follow range");
    idle_slot_a: assert property (!live |=> s_dark)
        else $error("settings applied with no live slot");
    offset_gate_a: assert property (!exposure_active |=> s_no_offset)
        else $error("offset current outside exposure");
    burst_ignore_a: assert property (ambient_reject_method |-> burst_average_sel == 3'h0)
        else $error("averaging kept under forward difference");
    led_settle_a: assert property (integration_start |-> led_age inside {[200:202], [300:302], [400:402], [600:602]})
        else $error("integration start at wrong delay");
    pd_settle_a: assert property (exposure_sample_start |-> pd_age inside {[203:205], [303:305], [403:405], [603:605], [803:805], [1203:1205], [1603:1605], [2003:2005]})
        else $error("exposure sample at wrong delay");
    start_pulse_a: assert property (integration_start |=> !integration_start)
        else $error("integration start longer than a cycle");
endmodule // omc_config_bank_chk
////////////////////////////////////////////////////////////////////////////
bind omc_config_bank omc_config_bank_chk omc_config_bank_chk_i (
    .aclk, .aresetn, .slot_run, .active_slot, .led_turn_on,
    .dark_sample_done, .exposure_active, .led_driver_a_en,
    .driver_a_current_code, .led_driver_a_current, .led_driver_b_en,
    .driver_b_current_code, .led_driver_b_current, .led_current_range,
    .led_full_scale_ma, .burst_average_sel, .ambient_reject_method,
    .offset_current_1_ua, .offset_current_2_ua, .integration_start,
    .exposure_sample_start);
`default_nettype wire

// ---- omc_regs.vh ----
`ifndef OMC_REGS_VH
`define OMC_REGS_VH

// register indices; byte address is four times the index
`define OMC_IDX_MEAS1_OFFSET_DAC_CFG  8'h24
`define OMC_IDX_MEAS1_DRIVER_A        8'h25
`define OMC_IDX_MEAS1_DRIVER_B        8'h26
`define OMC_IDX_MEAS2_SOURCE_SELECT   8'h28
`define OMC_IDX_MEAS2_TIMING_CFG      8'h29
`define OMC_IDX_MEAS2_RANGE_FILTER    8'h2A
`define OMC_IDX_FIRST_SLOT            8'h20
`define OMC_IDX_LAST_SLOT             8'h4F
`define OMC_NUM_SLOTS                 6

// position of each register inside one slot of eight indices
`define OMC_K_SELECT                  3'h0
`define OMC_K_CFG1                    3'h1
`define OMC_K_CFG2                    3'h2
`define OMC_K_CFG3                    3'h3
`define OMC_K_CFG4                    3'h4
`define OMC_K_DRV_A                   3'h5
`define OMC_K_DRV_B                   3'h6

// implemented bits per register
`define OMC_MASK_SELECT               8'h4F
`define OMC_MASK_CFG1                 8'hDF
`define OMC_MASK_CFG2                 8'hFF
`define OMC_MASK_CFG3                 8'hF8
`define OMC_MASK_CFG4                 8'h77
`define OMC_MASK_DRV                  8'hFF

// reset values
`define OMC_RST_SELECT                8'h00
`define OMC_RST_CFG1                  8'h18
`define OMC_RST_CFG2                  8'h3A
`define OMC_RST_CFG3                  8'h28
`define OMC_RST_CFG4                  8'h00
`define OMC_RST_DRV                   8'h00

// field positions
`define OMC_F_NO_LED_SAMPLE           6
`define OMC_F_DRV_B_PIN_HI            3
`define OMC_F_DRV_B_PIN_LO            2
`define OMC_F_DRV_A_PIN_HI            1
`define OMC_F_DRV_A_PIN_LO            0
`define OMC_F_PD_ROUTE_HI             7
`define OMC_F_PD_ROUTE_LO             6
`define OMC_F_TINT_HI                 4
`define OMC_F_TINT_LO                 3
`define OMC_F_AVER_HI                 2
`define OMC_F_AVER_LO                 0
`define OMC_F_CUBIC_EN                7
`define OMC_F_AMB_METHOD              6
`define OMC_F_LED_RANGE_HI            5
`define OMC_F_LED_RANGE_LO            4
`define OMC_F_ADC2_HI                 3
`define OMC_F_ADC2_LO                 2
`define OMC_F_ADC1_HI                 1
`define OMC_F_ADC1_LO                 0
`define OMC_F_PD_SETTLE_HI            7
`define OMC_F_PD_SETTLE_LO            5
`define OMC_F_LED_SETTLE_HI           4
`define OMC_F_LED_SETTLE_LO           3
`define OMC_F_OFS2_HI                 6
`define OMC_F_OFS2_LO                 4
`define OMC_F_OFS1_HI                 2
`define OMC_F_OFS1_LO                 0

// offset dac step in microamps
`define OMC_OFS_STEP_UA               5'h04

// settle times in 40 ns cycles, rounded up so no wait comes out short
`define OMC_LED_SETTLE0_CYC           12'h0C8
`define OMC_LED_SETTLE1_CYC           12'h12C
`define OMC_LED_SETTLE2_CYC           12'h190
`define OMC_LED_SETTLE3_CYC           12'h258
`define OMC_PD_SETTLE0_CYC            12'h0CB
`define OMC_PD_SETTLE1_CYC            12'h12F
`define OMC_PD_SETTLE2_CYC            12'h193
`define OMC_PD_SETTLE3_CYC            12'h25B
`define OMC_PD_SETTLE4_CYC            12'h323
`define OMC_PD_SETTLE5_CYC            12'h4B3
`define OMC_PD_SETTLE6_CYC            12'h643
`define OMC_PD_SETTLE7_CYC            12'h7D3

`define OMC_RESP_OKAY                 2'h0
`define OMC_RESP_SLVERR               2'h2

`endif
